// [rtl/pcg_flag_cell.sv]
// Purpose: One bitmap bit with hardware set, software set and software clear
// Assumes: Synchronous active-low reset
// Notes:   Any set beats a clear in the same cycle
`timescale 1ns/1ps
module pcg_flag_cell #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Controls
  input  wire logic hw_set,
  input  wire logic sw_set,
  input  wire logic sw_clr,
  // State
  output logic      q
);

  logic next_q;

  always_comb begin
    next_q = q;
    if (sw_clr) begin
      next_q = 1'b0;
    end
    if (hw_set || sw_set) begin
      next_q = 1'b1; // Set wins so no event is lost
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      q <= RST_VAL;
    end else begin
      q <= next_q;
    end
  end

endmodule

// [rtl/pcg_regs.sv]
// Purpose: Control and status registers of one performance counter group
// Assumes: Memory-mapped port with one request per cycle, answer one cycle later
// Notes:   Counters, filters and message address registers live outside
//
// Overview of operation
// - Writing 1 in the enable clear view clears that enable; reads show all enables.
// - Bitmap bits above the last implemented counter read zero and ignore writes.
// - Writing 1 in the overflow clear view clears that flag; reads show all flags.
// - A counter wrapping past its maximum sets its overflow flag.
// - Overflow may raise the group interrupt and trigger a capture when enabled.
// - Writing 1 in the overflow set view sets that flag; reads match clear view.
// - Software-set flags here never raise interrupt or capture; fixed behaviour.
// - Writing 1 to snapshot bit 0 copies all counters into their shadows.
// - Snapshot register reads zero; without capture support the trigger does nothing.
// - Security control bit 31 is read-only one.
// - Bit 3 gives partition namespace of secure messages; reset 0, else reserved.
// - Bit 2 selects message nonsecure attribute; resets 1; reserved without messages.
// - Bit 1 at 0 makes all nonsecure accesses read zero and ignore writes.
// - With nonsecure access enabled, every message carries nonsecure attribute one.
// - Bit 0 at 0 forces every secure stream filter select to zero.
// - Security control is read-write for secure, read-zero write-ignore otherwise.
// - Without two security states the security control reads zero, ignores writes.
// - Without two security states all accesses pass and messages are nonsecure.
// - Configuration bit 25 reads one only when partition filtering exists.
// - Overflow interrupts only when counter interrupt enable and group enable are both set.
// - A counter counts only when its enable and the global enable are set.
`timescale 1ns/1ps
module pcg_regs #(
  parameter int         NUM_CTR        = 64,
  parameter bit         HAS_SECURITY   = 1'b1,
  parameter bit         HAS_MSG_IRQ    = 1'b1,
  parameter bit         HAS_CAPTURE    = 1'b1,
  parameter bit         HAS_PART_NS    = 1'b1,
  parameter bit         HAS_PART_FILT  = 1'b1,
  parameter logic [5:0] CTR_SIZE_M1    = 6'h3f
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // Register port
  input  wire pcg_pkg::pcg_req_t    reg_req,
  output pcg_pkg::pcg_rsp_t         reg_rsp,
  // Counter events and controls from the counter array
  input  wire logic [NUM_CTR-1:0]   counter_wrap,
  input  wire logic [NUM_CTR-1:0]   counter_count_enable,
  input  wire logic                 global_count_enable,
  input  wire logic [NUM_CTR-1:0]   overflow_capture_enable,
  input  wire logic                 group_irq_enable,
  input  wire logic [NUM_CTR-1:0]   secure_stream_filter_sel,
  // Effective controls back to the counter array
  output logic [NUM_CTR-1:0]        count_allow,
  output logic [NUM_CTR-1:0]        eff_secure_stream_filter_sel,
  output logic                      capture_pulse,
  // Interrupt message attributes
  output logic                      group_irq_pulse,
  output logic                      msg_nonsecure_attr,
  output logic                      secure_msg_partition_namespace
);

  // One bitmap word serves at most 64 counters
  if (NUM_CTR < 1 || NUM_CTR > 64) begin : g_bad_num_ctr
    $error("NUM_CTR must be 1 to 64");
  end

  // Storage shared by both views of each bitmap
  logic [NUM_CTR-1:0] counter_irq_enable;
  logic [NUM_CTR-1:0] overflow_flag;

  // Security control fields
  logic sec_part_ns;
  logic sec_msg_ns;
  logic nonsecure_reg_access_en;
  logic sec_observe;

  // Decoded access strobes
  logic               acc_ok;
  logic               wr_ok;
  logic               sec_wr;
  logic [NUM_CTR-1:0] ien_set_w;
  logic [NUM_CTR-1:0] ien_clr_w;
  logic [NUM_CTR-1:0] ovf_set_w;
  logic [NUM_CTR-1:0] ovf_clr_w;
  logic               snap_w;

  // Next values
  logic                 next_sec_part_ns;
  logic                 next_sec_msg_ns;
  logic                 next_nonsecure_reg_access_en;
  logic                 next_sec_observe;
  pcg_pkg::pcg_rsp_t    next_reg_rsp;
  logic [NUM_CTR-1:0]   next_count_allow;
  logic [NUM_CTR-1:0]   next_eff_sel;
  logic                 next_capture_pulse;
  logic                 next_group_irq_pulse;
  logic                 next_msg_nonsecure_attr;
  logic                 next_part_ns_out;

  // Read helpers
  logic [63:0] ien_rd;
  logic [63:0] ovf_rd;
  logic [31:0] sec_rd;
  logic [31:0] cfg_rd;
  logic        part_ns_live;
  logic        msgs_nonsecure;

  // Access gating and write strobes
  always_comb begin
    acc_ok = reg_req.valid &&
             (!HAS_SECURITY || reg_req.secure || nonsecure_reg_access_en);
    wr_ok  = acc_ok && reg_req.write;
    sec_wr = wr_ok && HAS_SECURITY && reg_req.secure &&
             (reg_req.addr == pcg_pkg::OFS_SEC_CTRL);
    ien_set_w = '0;
    ien_clr_w = '0;
    ovf_set_w = '0;
    ovf_clr_w = '0;
    // Only implemented bits are taken; upper write data is dropped
    if (wr_ok && reg_req.addr == pcg_pkg::OFS_IRQ_EN_SET) begin
      ien_set_w = reg_req.wdata[NUM_CTR-1:0];
    end
    if (wr_ok && reg_req.addr == pcg_pkg::OFS_IRQ_EN_CLR) begin
      ien_clr_w = reg_req.wdata[NUM_CTR-1:0];
    end
    if (wr_ok && reg_req.addr == pcg_pkg::OFS_OVF_CLR) begin
      ovf_clr_w = reg_req.wdata[NUM_CTR-1:0];
    end
    if (wr_ok && reg_req.addr == pcg_pkg::OFS_OVF_SET) begin
      ovf_set_w = reg_req.wdata[NUM_CTR-1:0];
    end
    snap_w = HAS_CAPTURE && wr_ok && (reg_req.addr == pcg_pkg::OFS_SNAPSHOT) &&
             reg_req.wdata[pcg_pkg::SNAP_TRIG_BIT];
  end

  // One cell per counter for each shared bitmap
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_bit
    pcg_flag_cell #(
      .RST_VAL (pcg_pkg::BITMAP_RST)
    ) u_ien (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .hw_set  (1'b0),
      .sw_set  (ien_set_w[i]),
      .sw_clr  (ien_clr_w[i]),
      .q       (counter_irq_enable[i])
    );
    pcg_flag_cell #(
      .RST_VAL (pcg_pkg::BITMAP_RST)
    ) u_ovf (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .hw_set  (counter_wrap[i]),
      .sw_set  (ovf_set_w[i]),
      .sw_clr  (ovf_clr_w[i]),
      .q       (overflow_flag[i])
    );
  end

  // Read data assembly
  always_comb begin
    ien_rd = '0;
    ovf_rd = '0;
    ien_rd[NUM_CTR-1:0] = counter_irq_enable;
    ovf_rd[NUM_CTR-1:0] = overflow_flag;
    // Bit 3 is reserved while messages are configured nonsecure
    part_ns_live = HAS_PART_NS && HAS_MSG_IRQ && !sec_msg_ns && !nonsecure_reg_access_en;
    sec_rd = '0;
    if (HAS_SECURITY && reg_req.secure) begin
      sec_rd[pcg_pkg::SEC_PRESENT_BIT] = 1'b1;
      sec_rd[pcg_pkg::SEC_PART_NS_BIT] = part_ns_live && sec_part_ns;
      sec_rd[pcg_pkg::SEC_MSG_NS_BIT]  = HAS_MSG_IRQ && sec_msg_ns;
      sec_rd[pcg_pkg::SEC_NS_ACC_BIT]  = nonsecure_reg_access_en;
      sec_rd[pcg_pkg::SEC_OBSERVE_BIT] = sec_observe;
    end
    cfg_rd = '0;
    cfg_rd[pcg_pkg::CFG_PARTFILT_BIT] = HAS_PART_FILT;
    cfg_rd[pcg_pkg::CFG_CAPTURE_BIT]  = HAS_CAPTURE;
    cfg_rd[pcg_pkg::CFG_MSG_BIT]      = HAS_MSG_IRQ;
    cfg_rd[pcg_pkg::CFG_SIZE_LSB+:6]  = CTR_SIZE_M1;
    cfg_rd[pcg_pkg::CFG_NCTR_LSB+:6]  = 6'(NUM_CTR - 1);
  end

  // Security control next state
  always_comb begin
    next_sec_part_ns             = sec_part_ns;
    next_sec_msg_ns              = sec_msg_ns;
    next_nonsecure_reg_access_en = nonsecure_reg_access_en;
    next_sec_observe             = sec_observe;
    if (sec_wr) begin
      if (HAS_PART_NS) begin
        next_sec_part_ns = reg_req.wdata[pcg_pkg::SEC_PART_NS_BIT];
      end
      if (HAS_MSG_IRQ) begin
        next_sec_msg_ns = reg_req.wdata[pcg_pkg::SEC_MSG_NS_BIT];
      end
      next_nonsecure_reg_access_en = reg_req.wdata[pcg_pkg::SEC_NS_ACC_BIT];
      next_sec_observe             = reg_req.wdata[pcg_pkg::SEC_OBSERVE_BIT];
    end
  end

  // Answer and output next state
  always_comb begin
    next_reg_rsp       = '0;
    next_reg_rsp.valid = reg_req.valid;
    if (acc_ok && !reg_req.write) begin
      case (reg_req.addr)
        pcg_pkg::OFS_IRQ_EN_SET: next_reg_rsp.rdata = ien_rd;
        pcg_pkg::OFS_IRQ_EN_CLR: next_reg_rsp.rdata = ien_rd;
        pcg_pkg::OFS_OVF_CLR:    next_reg_rsp.rdata = ovf_rd;
        pcg_pkg::OFS_OVF_SET:    next_reg_rsp.rdata = ovf_rd;
        pcg_pkg::OFS_SNAPSHOT:   next_reg_rsp.rdata = '0;
        pcg_pkg::OFS_SEC_CTRL:   next_reg_rsp.rdata = {32'h0, sec_rd};
        pcg_pkg::OFS_GROUP_CFG:  next_reg_rsp.rdata = {32'h0, cfg_rd};
        default:                 next_reg_rsp.rdata = '0;
      endcase
    end
    next_count_allow = counter_count_enable & {NUM_CTR{global_count_enable}};
    // Without secure observation the programmed select has no effect
    next_eff_sel = secure_stream_filter_sel &
                   {NUM_CTR{HAS_SECURITY && sec_observe}};
    // Only hardware wraps and snapshot writes carry side effects; software flag sets stay silent
    next_group_irq_pulse = group_irq_enable &&
                           |(counter_wrap & counter_irq_enable);
    next_capture_pulse   = snap_w ||
                           (HAS_CAPTURE && |(counter_wrap & overflow_capture_enable));
    msgs_nonsecure = !HAS_SECURITY || nonsecure_reg_access_en || sec_msg_ns;
    next_msg_nonsecure_attr = msgs_nonsecure;
    next_part_ns_out = !msgs_nonsecure && HAS_PART_NS && sec_part_ns;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sec_part_ns                    <= pcg_pkg::SEC_PART_NS_RST;
      sec_msg_ns                     <= pcg_pkg::SEC_MSG_NS_RST;
      nonsecure_reg_access_en        <= pcg_pkg::SEC_NS_ACC_RST;
      sec_observe                    <= pcg_pkg::SEC_OBSERVE_RST;
      reg_rsp                        <= '0;
      count_allow                    <= '0;
      eff_secure_stream_filter_sel   <= '0;
      capture_pulse                  <= 1'b0;
      group_irq_pulse                <= 1'b0;
      msg_nonsecure_attr             <= 1'b1;
      secure_msg_partition_namespace <= 1'b0;
    end else begin
      sec_part_ns                    <= next_sec_part_ns;
      sec_msg_ns                     <= next_sec_msg_ns;
      nonsecure_reg_access_en        <= next_nonsecure_reg_access_en;
      sec_observe                    <= next_sec_observe;
      reg_rsp                        <= next_reg_rsp;
      count_allow                    <= next_count_allow;
      eff_secure_stream_filter_sel   <= next_eff_sel;
      capture_pulse                  <= next_capture_pulse;
      group_irq_pulse                <= next_group_irq_pulse;
      msg_nonsecure_attr             <= next_msg_nonsecure_attr;
      secure_msg_partition_namespace <= next_part_ns_out;
    end
  end

endmodule

// [shared/pcg_pkg.sv]
// Purpose: Shared constants and carriers for the counter group control block
// Assumes: 12-bit byte address space, 64-bit register data path
// Notes:   Registers narrower than 64 bits sit in the low bits
package pcg_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_IRQ_EN_SET   = 12'hc40;
  localparam logic [11:0] OFS_IRQ_EN_CLR   = 12'hc60;
  localparam logic [11:0] OFS_OVF_CLR      = 12'hc80;
  localparam logic [11:0] OFS_OVF_SET      = 12'hcc0;
  localparam logic [11:0] OFS_SNAPSHOT     = 12'hd88;
  localparam logic [11:0] OFS_SEC_CTRL     = 12'hdf8;
  localparam logic [11:0] OFS_GROUP_CFG    = 12'he00;

  // Security control field positions
  localparam int SEC_PRESENT_BIT  = 31;
  localparam int SEC_PART_NS_BIT  = 3;
  localparam int SEC_MSG_NS_BIT   = 2;
  localparam int SEC_NS_ACC_BIT   = 1;
  localparam int SEC_OBSERVE_BIT  = 0;

  // Security control reset values
  localparam logic SEC_PART_NS_RST = 1'b0;
  localparam logic SEC_MSG_NS_RST  = 1'b1;
  localparam logic SEC_NS_ACC_RST  = 1'b1;
  localparam logic SEC_OBSERVE_RST = 1'b0;

  // Configuration field positions
  localparam int CFG_PARTFILT_BIT = 25;
  localparam int CFG_CAPTURE_BIT  = 22;
  localparam int CFG_MSG_BIT      = 21;
  localparam int CFG_SIZE_LSB     = 8;
  localparam int CFG_NCTR_LSB     = 0;

  // Snapshot trigger bit
  localparam int SNAP_TRIG_BIT    = 0;

  // Bitmap reset values
  localparam logic BITMAP_RST     = 1'b0;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        secure;
    logic [11:0] addr;
    logic [63:0] wdata;
  } pcg_req_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] rdata;
  } pcg_rsp_t;

endpackage

// [verification/pcg_regs_chk.sv]
// Purpose: Port-level assertions for the counter group register block
// Assumes: One clock, synchronous active-low reset, answer one cycle after request
// Notes:   Bound to every pcg_regs instance
`timescale 1ns/1ps
module pcg_regs_chk #(
  parameter int NUM_CTR = 64
) (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               rst_b,
  // Register port
  input wire pcg_pkg::pcg_req_t  reg_req,
  input wire pcg_pkg::pcg_rsp_t  reg_rsp,
  // Counter side
  input wire logic [NUM_CTR-1:0] counter_wrap,
  input wire logic [NUM_CTR-1:0] counter_count_enable,
  input wire logic               global_count_enable,
  input wire logic [NUM_CTR-1:0] overflow_capture_enable,
  input wire logic               group_irq_enable,
  input wire logic [NUM_CTR-1:0] secure_stream_filter_sel,
  input wire logic [NUM_CTR-1:0] count_allow,
  input wire logic [NUM_CTR-1:0] eff_secure_stream_filter_sel,
  input wire logic               capture_pulse,
  input wire logic               group_irq_pulse,
  input wire logic               msg_nonsecure_attr,
  input wire logic               secure_msg_partition_namespace
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence rd_s;
    reg_req.valid && !reg_req.write;
  endsequence
  sequence snap_wr_s;
    reg_req.valid && reg_req.write && reg_req.secure && reg_req.addr == pcg_pkg::OFS_SNAPSHOT && reg_req.wdata[0];
  endsequence
  rsp_follows_a: assert property (reg_req.valid |=> reg_rsp.valid) else $error("no answer after request");
  rsp_alone_a: assert property (!reg_req.valid |=> !reg_rsp.valid) else $error("answer without request");
  snap_reads_zero_a: assert property (rd_s ##0 reg_req.addr == pcg_pkg::OFS_SNAPSHOT |=> reg_rsp.rdata == 64'h0)
    else $error("snapshot read not zero");
  ns_secctrl_a: assert property (rd_s ##0 !reg_req.secure && reg_req.addr == pcg_pkg::OFS_SEC_CTRL
    |=> reg_rsp.rdata == 64'h0) else $error("nonsecure control read not zero");
  snap_capture_a: assert property (snap_wr_s |=> capture_pulse) else $error("snapshot write gave no capture");
  wrap_capture_a: assert property (|(counter_wrap & overflow_capture_enable) |=> capture_pulse)
    else $error("enabled wrap gave no capture");
  irq_cause_a: assert property (group_irq_pulse |-> $past(group_irq_enable) && $past(|counter_wrap))
    else $error("interrupt without enabled wrap");
  count_gate_a: assert property ($past(rst_b) |-> count_allow ==
    $past(counter_count_enable & {NUM_CTR{global_count_enable}})) else $error("count allow wrong");
  filter_gate_a: assert property ($past(rst_b) |->
    (eff_secure_stream_filter_sel & ~$past(secure_stream_filter_sel)) == '0) else $error("filter select leaked");
  part_ns_a: assert property (msg_nonsecure_attr |-> !secure_msg_partition_namespace)
    else $error("namespace driven on nonsecure messages");
endmodule
bind pcg_regs pcg_regs_chk #(.NUM_CTR(NUM_CTR)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rsp(reg_rsp), .counter_wrap(counter_wrap), .counter_count_enable(counter_count_enable),
  .global_count_enable(global_count_enable), .overflow_capture_enable(overflow_capture_enable),
  .group_irq_enable(group_irq_enable), .secure_stream_filter_sel(secure_stream_filter_sel),
  .count_allow(count_allow), .eff_secure_stream_filter_sel(eff_secure_stream_filter_sel),
  .capture_pulse(capture_pulse), .group_irq_pulse(group_irq_pulse), .msg_nonsecure_attr(msg_nonsecure_attr),
  .secure_msg_partition_namespace(secure_msg_partition_namespace));

// [verification/pcg_regs_test.sv]
// Purpose: Self-checking bench for the counter group register block
// Assumes: Eight counters so the upper bitmap bits are unimplemented
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module perf_counter_group_control_test;
  logic              sys_clk = 1'b0;
  logic              rst_b = 1'b0;
  pcg_pkg::pcg_req_t req;
  pcg_pkg::pcg_rsp_t rsp;
  logic [7:0]        wrap, cen, cap_en, sel, allow, eff;
  logic              gce, gie, cap, irq, msg_ns, part_ns;
  logic [63:0]       rd;
  int                n_errors = 0;
  int                comparisons = 0;

  pcg_regs #(.NUM_CTR(8)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_req(req), .reg_rsp(rsp),
    .counter_wrap(wrap), .counter_count_enable(cen), .global_count_enable(gce),
    .overflow_capture_enable(cap_en), .group_irq_enable(gie), .secure_stream_filter_sel(sel),
    .count_allow(allow), .eff_secure_stream_filter_sel(eff), .capture_pulse(cap), .group_irq_pulse(irq),
    .msg_nonsecure_attr(msg_ns), .secure_msg_partition_namespace(part_ns));

  always #20 sys_clk = ~sys_clk;

  task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request held from just after one edge to just after the taking edge
  task acc(input logic w, input logic s, input logic [11:0] a, input logic [63:0] d);
    @(posedge sys_clk);
    #1;
    req = '{valid: 1'b1, write: w, secure: s, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    req.valid = 1'b0;
    rd = rsp.rdata;
    chk("rsp_valid", 64'h1, {63'h0, rsp.valid});
  endtask

  task rdc(input string n, input logic s, input logic [11:0] a, input logic [63:0] e);
    acc(1'b0, s, a, 64'h0);
    chk(n, e, rd);
  endtask

  task pulse_wrap(input logic [7:0] m);
    @(posedge sys_clk);
    #1;
    wrap = m;
    @(posedge sys_clk);
    #1;
    wrap = 8'h00;
  endtask

  task t_reset;
    rdc("sec_ctrl", 1'b1, pcg_pkg::OFS_SEC_CTRL, 64'h80000006);
    rdc("counter_irq_enable", 1'b1, pcg_pkg::OFS_IRQ_EN_CLR, 64'h0);
    rdc("config", 1'b1, pcg_pkg::OFS_GROUP_CFG, 64'h02603f07);
    rdc("unmapped", 1'b1, 12'h100, 64'h0);
    $display("test reset done");
  endtask

  task t_counter_irq_enable;
    acc(1'b1, 1'b1, pcg_pkg::OFS_IRQ_EN_SET, 64'hffffffffffffffff);
    rdc("counter_irq_enable_clr", 1'b1, pcg_pkg::OFS_IRQ_EN_CLR, 64'hff);
    acc(1'b1, 1'b1, pcg_pkg::OFS_IRQ_EN_CLR, 64'hffffffffffffff0d);
    rdc("counter_irq_enable_set", 1'b1, pcg_pkg::OFS_IRQ_EN_SET, 64'hf2);
    $display("test counter_irq_enable done");
  endtask

  task t_ovf;
    gie = 1'b1;
    cap_en = 8'hff;
    acc(1'b1, 1'b1, pcg_pkg::OFS_OVF_SET, 64'hffffffffffffffa5);
    chk("sw_set_irq", 64'h0, {63'h0, irq});
    chk("sw_set_cap", 64'h0, {63'h0, cap});
    rdc("ovf_clr", 1'b1, pcg_pkg::OFS_OVF_CLR, 64'ha5);
    acc(1'b1, 1'b1, pcg_pkg::OFS_OVF_CLR, 64'h05);
    rdc("ovf_set", 1'b1, pcg_pkg::OFS_OVF_SET, 64'ha0);
    pulse_wrap(8'h02);
    chk("hw_irq", 64'h1, {63'h0, irq});
    chk("hw_capture", 64'h1, {63'h0, cap});
    rdc("ovf_wrap", 1'b1, pcg_pkg::OFS_OVF_CLR, 64'ha2);
    pulse_wrap(8'h01);
    chk("masked_irq", 64'h0, {63'h0, irq});
    fork
      acc(1'b1, 1'b1, pcg_pkg::OFS_OVF_CLR, 64'h20);
      pulse_wrap(8'h20);
    join
    rdc("ovf_race", 1'b1, pcg_pkg::OFS_OVF_CLR, 64'ha3);
    $display("test overflow done");
  endtask

  task t_sec;
    acc(1'b1, 1'b1, pcg_pkg::OFS_SEC_CTRL, 64'h4);
    gie = 1'b0;
    pulse_wrap(8'h02);
    chk("irq_group_off", 64'h0, {63'h0, irq});
    chk("handover_ns", 64'h1, {63'h0, msg_ns});
    sel = 8'h3c;
    acc(1'b1, 1'b1, pcg_pkg::OFS_SEC_CTRL, 64'h9);
    rdc("sec_rw", 1'b1, pcg_pkg::OFS_SEC_CTRL, 64'h80000009);
    chk("msg_ns", 64'h0, {63'h0, msg_ns});
    chk("part_ns", 64'h1, {63'h0, part_ns});
    chk("eff_sel", 64'h3c, {56'h0, eff});
    rdc("ns_blocked", 1'b0, pcg_pkg::OFS_OVF_CLR, 64'h0);
    acc(1'b1, 1'b0, pcg_pkg::OFS_IRQ_EN_SET, 64'hff);
    rdc("ns_write", 1'b1, pcg_pkg::OFS_IRQ_EN_SET, 64'hf2);
    acc(1'b1, 1'b0, pcg_pkg::OFS_SEC_CTRL, 64'h6);
    rdc("ns_sec_ctrl", 1'b1, pcg_pkg::OFS_SEC_CTRL, 64'h80000009);
    acc(1'b1, 1'b1, pcg_pkg::OFS_SEC_CTRL, 64'ha);
    rdc("ns_sec_read", 1'b0, pcg_pkg::OFS_SEC_CTRL, 64'h0);
    rdc("sec_reserved", 1'b1, pcg_pkg::OFS_SEC_CTRL, 64'h80000002);
    chk("msg_ns_on", 64'h1, {63'h0, msg_ns});
    chk("part_ns_off", 64'h0, {63'h0, part_ns});
    chk("eff_off", 64'h0, {56'h0, eff});
    $display("test security done");
  endtask

  task t_misc;
    acc(1'b1, 1'b1, pcg_pkg::OFS_SNAPSHOT, 64'h1);
    chk("snap_capture", 64'h1, {63'h0, cap});
    rdc("snap_read", 1'b1, pcg_pkg::OFS_SNAPSHOT, 64'h0);
    cen = 8'h55;
    gce = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("allow_on", 64'h55, {56'h0, allow});
    gce = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("allow_off", 64'h0, {56'h0, allow});
    $display("test misc done");
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    #(40 * 5000);
    n_errors++;
    conclude();
  end

  initial begin
    req = '0;
    wrap = 8'h00;
    cen = 8'h00;
    cap_en = 8'h00;
    sel = 8'h00;
    gce = 1'b0;
    gie = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_counter_irq_enable();
    t_ovf();
    t_sec();
    t_misc();
    conclude();
  end
endmodule
